// ==== logic/fcs_pkg.sv ====
// constants, codes and types of the flash command sequencer host
package fcs_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WINDOW_NS = 50000;
  localparam int SUSPEND_NS = 15000;
  localparam int ABORT_NS = 10000;
  localparam int WE_PULSE_NS = 100;
  localparam int ACCESS_NS = 55;
  // a deadline rounds down, a least wait rounds up
  localparam int WINDOW_CYC = WINDOW_NS / CLK_PERIOD_NS;
  localparam int SUSPEND_CYC = (SUSPEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABORT_CYC = (ABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the device times its window from its own strobe, so an add taken on
  // the last counted cycle must still strobe inside it
  localparam int ADD_LAT_CYC = 4;
  localparam logic [9:0] WINDOW_CNT = 10'(WINDOW_CYC - ADD_LAT_CYC);
  localparam logic [9:0] SUSPEND_CNT = 10'(SUSPEND_CYC - 1);
  localparam logic [9:0] ABORT_CNT = 10'(ABORT_CYC - 1);
  localparam logic [9:0] WE_CNT = 10'(WE_CYC - 1);
  localparam logic [9:0] ACCESS_CNT = 10'(ACCESS_CYC - 1);
  localparam logic [18:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2 = 19'h002aa;
  localparam logic [10:0] CMD_ADDR_MASK = 11'h7ff;
  localparam logic [7:0] D_UNLOCK1 = 8'haa;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_RESET = 8'hf0;
  localparam logic [7:0] D_AUTOSEL = 8'h90;
  localparam logic [7:0] D_PROG = 8'ha0;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_BYP_EXIT = 8'h00;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_BLOCK = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hb0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET1 = 4'h1;
  localparam logic [3:0] OP_RESET3 = 4'h2;
  localparam logic [3:0] OP_AUTOSEL = 4'h3;
  localparam logic [3:0] OP_PROG = 4'h4;
  localparam logic [3:0] OP_BYP_ENTER = 4'h5;
  localparam logic [3:0] OP_BYP_RESET = 4'h6;
  localparam logic [3:0] OP_CHIP = 4'h7;
  localparam logic [3:0] OP_BLOCK = 4'h8;
  localparam logic [3:0] OP_BLOCK_ADD = 4'h9;
  localparam logic [3:0] OP_SUSPEND = 4'ha;
  localparam logic [3:0] OP_RESUME = 4'hb;
  localparam logic [3:0] OP_POLL = 4'hc;
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA = 3'h4;
  localparam int ST_BUSY = 0;
  localparam int ST_BYPASS = 1;
  localparam int ST_SUSP = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_ERROR = 4;
  localparam int ST_LATE = 5;
  localparam int ST_WINDOW = 6;
  localparam int ST_PROG_BUSY = 7;
  localparam int ST_BLK_ERASE = 8;
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] dq;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fcs_bus_t;
  localparam fcs_bus_t BUS_IDLE = '{19'h00000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1};
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } fcs_step_t;
endpackage

// ==== logic/fcs_host.sv ====
// host side sequencer that drives a parallel nor flash command interface
// Contract
// (R1) bypass entry: AA@555, 55@2AA, 20@555
// (R2) in bypass only bypass program, reset
// (R3) bypass program: A0 anywhere, then target and value
// (R4) bypass program acts as normal; reset keeps bypass
// (R5) bypass exit: 90 then 00, anywhere
// (R6) read/reset: F0 alone or after unlock pair
// (R7) auto select: unlock pair then 90@555
// (R8) program: unlock, A0@555, then target and value
// (R9) decoder checks only low eleven address bits
// (R10) chip erase: six writes ending 10@555
// (R11) protected blocks skipped silently during erase
// (R12) chip erase ignores commands, reads give status
// (R13) error holds status until read/reset clears it
// (R14) erase sets unprotected target blocks to ones
// (R15) block erase ends 30@block; repeat adds blocks
// (R16) add blocks within 50us selection window
// (R17) block erase accepts only suspend and reset
// (R18) suspend B0 anywhere; halt within 15us
// (R19) suspend in window acts at once; resume closes
// (R20) during suspend other blocks read, program normally
// (R21) auto select in suspend; reset returns to suspend
// (R22) resume 30 anywhere; repeatable within one erase
// (R23) invalid sequence returns device to read mode
// (R24) reset during erase or error: 10us abort
// (R25) erase timer flag rises when erasing starts
// (R26) device durations come from shortenable counters
`timescale 1ns/100ps
module fcs_host (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [18:0] flash_addr_out,
  output logic [7:0] flash_dq_out,
  input wire logic [7:0] flash_dq_in,
  output logic flash_dq_oe_n_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_WSET = 7'h02,
    S_WLOW = 7'h04,
    S_WHOLD = 7'h08,
    S_DELAY = 7'h10,
    S_RLOW = 7'h20,
    S_RREL = 7'h40
  } fcs_state_t;

  fcs_state_t state, next_state;
  fcs_pkg::fcs_bus_t bus, next_bus;
  logic [3:0] op, next_op;
  logic [2:0] step, next_step;
  logic [18:0] cmd_addr, next_cmd_addr;
  logic [7:0] cmd_data, next_cmd_data;
  logic [7:0] rdata, next_rdata;
  logic [7:0] prev_rd, next_prev_rd;
  logic have_prev, next_have_prev;
  logic err_seen, next_err_seen;
  logic bypass, next_bypass;
  logic suspended, next_suspended;
  logic prog_busy, next_prog_busy;
  logic blk_erase, next_blk_erase;
  logic poll_err, next_poll_err;
  logic refused, next_refused;
  logic late, next_late;
  logic [9:0] win_cnt, next_win_cnt;
  logic [9:0] dly_cnt, next_dly_cnt;
  logic wait_q, next_wait_q;
  logic [31:0] rd_q, next_rd_q;

  logic acc;
  logic take;
  logic [8:0] status;

  // write count of each order; zero means a read-only order
  function automatic logic [2:0] wr_len(input logic [3:0] o,
                                        input logic byp);
    case (o)
      fcs_pkg::OP_RESET1, fcs_pkg::OP_SUSPEND, fcs_pkg::OP_RESUME,
      fcs_pkg::OP_BLOCK_ADD: wr_len = 3'd1;
      fcs_pkg::OP_BYP_RESET: wr_len = 3'd2;
      fcs_pkg::OP_PROG: wr_len = byp ? 3'd2 : 3'd4;
      fcs_pkg::OP_RESET3, fcs_pkg::OP_AUTOSEL,
      fcs_pkg::OP_BYP_ENTER: wr_len = 3'd3;
      fcs_pkg::OP_CHIP, fcs_pkg::OP_BLOCK: wr_len = 3'd6;
      default: wr_len = 3'd0;
    endcase
  endfunction

  // address and data of write k; the unlock preamble is shared
  function automatic fcs_pkg::fcs_step_t step_of(input logic [3:0] o,
      input logic [2:0] k, input logic byp, input logic [18:0] a,
      input logic [7:0] d);
    fcs_pkg::fcs_step_t s;
    s.addr = (k == 3'd1 || k == 3'd4) ? fcs_pkg::ADDR_UNLOCK2 :
             fcs_pkg::ADDR_UNLOCK1;
    s.data = (k == 3'd1 || k == 3'd4) ? fcs_pkg::D_UNLOCK2 :
             fcs_pkg::D_UNLOCK1;
    case (o)
      fcs_pkg::OP_RESET1: s = '{a, fcs_pkg::D_RESET}; // [R6]
      fcs_pkg::OP_SUSPEND: s = '{a, fcs_pkg::D_SUSPEND}; // [R18]
      fcs_pkg::OP_RESUME: s = '{a, fcs_pkg::D_RESUME}; // [R22]
      fcs_pkg::OP_BLOCK_ADD: s = '{a, fcs_pkg::D_BLOCK}; // [R15]
      fcs_pkg::OP_BYP_RESET: begin
        s.addr = a;
        s.data = (k == 3'd0) ? fcs_pkg::D_AUTOSEL :
                 fcs_pkg::D_BYP_EXIT; // [R5]
      end
      fcs_pkg::OP_RESET3: begin
        if (k == 3'd2) s = '{a, fcs_pkg::D_RESET}; // [R6]
      end
      fcs_pkg::OP_AUTOSEL: begin
        if (k == 3'd2) s.data = fcs_pkg::D_AUTOSEL; // [R7]
      end
      fcs_pkg::OP_BYP_ENTER: begin
        if (k == 3'd2) s.data = fcs_pkg::D_BYPASS; // [R1]
      end
      fcs_pkg::OP_PROG: begin
        if (byp) begin
          s.addr = a;
          s.data = (k == 3'd0) ? fcs_pkg::D_PROG : d; // [R3]
        end else if (k == 3'd2) begin
          s.data = fcs_pkg::D_PROG; // [R8]
        end else if (k == 3'd3) begin
          s = '{a, d}; // [R8]
        end
      end
      fcs_pkg::OP_CHIP, fcs_pkg::OP_BLOCK: begin
        if (k == 3'd2) s.data = fcs_pkg::D_ERASE; // [R10]
        if (k == 3'd5 && o == fcs_pkg::OP_CHIP) begin
          s = '{fcs_pkg::ADDR_UNLOCK1, fcs_pkg::D_CHIP}; // [R10]
        end else if (k == 3'd5) begin
          s = '{a, fcs_pkg::D_BLOCK}; // [R15]
        end
      end
      default: s = '{a, d};
    endcase
    step_of = s;
  endfunction

  // orders that the device would ignore or abandon are never sent
  function automatic logic legal(input logic [3:0] o);
    logic rd;
    rd = (o == fcs_pkg::OP_READ) || (o == fcs_pkg::OP_POLL);
    if (poll_err) begin
      legal = rd || o == fcs_pkg::OP_RESET1 || o == fcs_pkg::OP_RESET3; // [R13]
    end else if (prog_busy) begin
      legal = rd; // [R12]
    end else if (blk_erase && !suspended) begin
      legal = rd || o == fcs_pkg::OP_SUSPEND || o == fcs_pkg::OP_RESET1 ||
              o == fcs_pkg::OP_RESET3 || o == fcs_pkg::OP_BLOCK_ADD; // [R17]
    end else if (suspended) begin
      legal = rd || o == fcs_pkg::OP_PROG || o == fcs_pkg::OP_AUTOSEL ||
              o == fcs_pkg::OP_RESET1 || o == fcs_pkg::OP_RESET3 ||
              o == fcs_pkg::OP_RESUME; // [R20] [R21] [R22]
    end else if (bypass) begin
      legal = rd || o == fcs_pkg::OP_PROG || o == fcs_pkg::OP_BYP_RESET ||
              o == fcs_pkg::OP_RESET1; // [R2] [R4]
    end else begin
      legal = o <= fcs_pkg::OP_CHIP && o != fcs_pkg::OP_BYP_RESET ||
              o == fcs_pkg::OP_BLOCK || rd;
    end
  endfunction

  assign acc = avs_read_in || avs_write_in;
  assign take = acc && !wait_q;
  assign status = {blk_erase, prog_busy, (win_cnt != 10'h000), late,
                   poll_err, refused, suspended, bypass, (state != S_IDLE)};

  always_comb begin
    next_state = state;
    next_bus = bus;
    next_op = op;
    next_step = step;
    next_cmd_addr = cmd_addr;
    next_cmd_data = cmd_data;
    next_rdata = rdata;
    next_prev_rd = prev_rd;
    next_have_prev = have_prev;
    next_err_seen = err_seen;
    next_bypass = bypass;
    next_suspended = suspended;
    next_prog_busy = prog_busy;
    next_blk_erase = blk_erase;
    next_poll_err = poll_err;
    next_refused = refused;
    next_late = late;
    next_dly_cnt = dly_cnt;
    // the window counts down until an added block reloads it; expiry closes further block selection
    next_win_cnt = (win_cnt != 10'h000) ? win_cnt - 10'h001 : win_cnt; // [R16]
    next_wait_q = !(acc && wait_q);
    next_rd_q = rd_q;
    if (acc && wait_q) begin
      case (avs_address_in)
        fcs_pkg::REG_ADDR: next_rd_q = {13'h0000, cmd_addr};
        fcs_pkg::REG_DATA: next_rd_q = {24'h000000, cmd_data};
        fcs_pkg::REG_STATUS: next_rd_q = {23'h000000, status};
        fcs_pkg::REG_RDATA: next_rd_q = {24'h000000, rdata};
        default: next_rd_q = 32'h00000000;
      endcase
    end
    if (take && avs_write_in) begin
      case (avs_address_in)
        fcs_pkg::REG_ADDR: next_cmd_addr = avs_writedata_in[18:0];
        fcs_pkg::REG_DATA: next_cmd_data = avs_writedata_in[7:0];
        fcs_pkg::REG_STATUS: begin
          if (avs_writedata_in[fcs_pkg::ST_REFUSED]) next_refused = 1'b0;
          if (avs_writedata_in[fcs_pkg::ST_LATE]) next_late = 1'b0;
        end
        default: ;
      endcase
    end
    // an order that arrives while a sequence runs is dropped, not queued
    if (take && avs_write_in && avs_address_in == fcs_pkg::REG_CMD &&
        state != S_IDLE) begin
      next_refused = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (take && avs_write_in && avs_address_in == fcs_pkg::REG_CMD) begin
          if (!legal(avs_writedata_in[3:0])) begin
            next_refused = 1'b1;
          end else if (avs_writedata_in[3:0] == fcs_pkg::OP_BLOCK_ADD &&
                       win_cnt == 10'h000) begin
            next_late = 1'b1; // [R16] [R19]
          end else begin
            next_op = avs_writedata_in[3:0];
            next_step = 3'd0;
            next_have_prev = 1'b0;
            next_err_seen = 1'b0;
            next_bus = fcs_pkg::BUS_IDLE;
            next_bus.ce_n = 1'b0;
            if (wr_len(avs_writedata_in[3:0], bypass) == 3'd0) begin
              next_bus.addr = cmd_addr;
              next_bus.oe_n = 1'b0;
              next_dly_cnt = fcs_pkg::ACCESS_CNT;
              next_state = S_RLOW;
            end else begin
              next_bus.dq_oe_n = 1'b0;
              next_bus.addr = step_of(avs_writedata_in[3:0], 3'd0, bypass,
                                      cmd_addr, cmd_data).addr;
              next_bus.dq = step_of(avs_writedata_in[3:0], 3'd0, bypass,
                                    cmd_addr, cmd_data).data;
              next_state = S_WSET;
            end
          end
        end
      end
      S_WSET: begin
        next_bus.we_n = 1'b0;
        next_dly_cnt = fcs_pkg::WE_CNT;
        next_state = S_WLOW;
      end
      S_WLOW: begin
        if (dly_cnt == 10'h000) begin
          next_bus.we_n = 1'b1;
          next_state = S_WHOLD;
        end else begin
          next_dly_cnt = dly_cnt - 10'h001;
        end
      end
      S_WHOLD: begin
        next_bus = fcs_pkg::BUS_IDLE;
        next_state = S_IDLE;
        if (step != wr_len(op, bypass) - 3'd1) begin
          next_step = step + 3'd1;
          next_bus.ce_n = 1'b0;
          next_bus.dq_oe_n = 1'b0;
          next_bus.addr = step_of(op, step + 3'd1, bypass, cmd_addr,
                                  cmd_data).addr;
          next_bus.dq = step_of(op, step + 3'd1, bypass, cmd_addr,
                                cmd_data).data;
          next_state = S_WSET;
        end else begin
          case (op)
            fcs_pkg::OP_BYP_ENTER: next_bypass = 1'b1; // [R1]
            fcs_pkg::OP_BYP_RESET: next_bypass = 1'b0; // [R5]
            fcs_pkg::OP_PROG, fcs_pkg::OP_CHIP: next_prog_busy = 1'b1;
            fcs_pkg::OP_BLOCK, fcs_pkg::OP_BLOCK_ADD: begin
              next_blk_erase = 1'b1;
              next_win_cnt = fcs_pkg::WINDOW_CNT; // [R16]
            end
            fcs_pkg::OP_SUSPEND: begin
              next_suspended = 1'b1;
              next_win_cnt = 10'h000; // [R19]
              next_dly_cnt = fcs_pkg::SUSPEND_CNT;
              next_state = S_DELAY; // [R18]
            end
            fcs_pkg::OP_RESUME: begin
              next_suspended = 1'b0;
              next_win_cnt = 10'h000; // [R19] [R22]
            end
            fcs_pkg::OP_RESET1, fcs_pkg::OP_RESET3: begin
              if (poll_err || (blk_erase && !suspended)) begin
                next_dly_cnt = fcs_pkg::ABORT_CNT;
                next_state = S_DELAY; // [R24]
              end
              next_poll_err = 1'b0; // [R13]
              next_prog_busy = 1'b0;
              if (!suspended) begin
                next_blk_erase = 1'b0; // [R21]
                next_win_cnt = 10'h000;
              end
            end
            default: ;
          endcase
        end
      end
      S_DELAY: begin
        if (dly_cnt == 10'h000) next_state = S_IDLE;
        else next_dly_cnt = dly_cnt - 10'h001;
      end
      S_RLOW: begin
        if (dly_cnt != 10'h000) begin
          next_dly_cnt = dly_cnt - 10'h001;
        end else begin
          next_rdata = flash_dq_in;
          next_bus.oe_n = 1'b1;
          next_bus.ce_n = 1'b1;
          next_state = S_IDLE;
          if (op == fcs_pkg::OP_POLL) begin
            // toggle bit at rest means the controller is done
            if (have_prev && prev_rd[6] == flash_dq_in[6]) begin
              if (!suspended) next_blk_erase = 1'b0;
              next_prog_busy = 1'b0;
              next_win_cnt = suspended ? win_cnt : 10'h000;
            end else if (have_prev && err_seen) begin
              next_poll_err = 1'b1; // [R13]
            end else begin
              next_err_seen = flash_dq_in[5];
              next_have_prev = 1'b1;
              next_prev_rd = flash_dq_in;
              next_state = S_RREL;
            end
          end
        end
      end
      S_RREL: begin
        // output enable must rise between reads or the toggle bit stalls
        next_bus.ce_n = 1'b0;
        next_bus.oe_n = 1'b0;
        next_dly_cnt = fcs_pkg::ACCESS_CNT;
        next_state = S_RLOW;
      end
      default: begin
        next_state = S_IDLE;
        next_bus = fcs_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= S_IDLE;
      bus <= fcs_pkg::BUS_IDLE;
      op <= fcs_pkg::OP_READ;
      step <= 3'd0;
      cmd_addr <= 19'h00000;
      cmd_data <= 8'h00;
      rdata <= 8'h00;
      prev_rd <= 8'h00;
      have_prev <= 1'b0;
      err_seen <= 1'b0;
      bypass <= 1'b0;
      suspended <= 1'b0;
      prog_busy <= 1'b0;
      blk_erase <= 1'b0;
      poll_err <= 1'b0;
      refused <= 1'b0;
      late <= 1'b0;
      win_cnt <= 10'h000;
      dly_cnt <= 10'h000;
      wait_q <= 1'b1;
      rd_q <= 32'h00000000;
    end else begin
      state <= next_state;
      bus <= next_bus;
      op <= next_op;
      step <= next_step;
      cmd_addr <= next_cmd_addr;
      cmd_data <= next_cmd_data;
      rdata <= next_rdata;
      prev_rd <= next_prev_rd;
      have_prev <= next_have_prev;
      err_seen <= next_err_seen;
      bypass <= next_bypass;
      suspended <= next_suspended;
      prog_busy <= next_prog_busy;
      blk_erase <= next_blk_erase;
      poll_err <= next_poll_err;
      refused <= next_refused;
      late <= next_late;
      win_cnt <= next_win_cnt;
      dly_cnt <= next_dly_cnt;
      wait_q <= next_wait_q;
      rd_q <= next_rd_q;
    end
  end

  assign avs_readdata_out = rd_q;
  assign avs_waitrequest_out = wait_q;
  assign flash_addr_out = bus.addr;
  assign flash_dq_out = bus.dq;
  assign flash_dq_oe_n_out = bus.dq_oe_n;
  assign flash_ce_n_out = bus.ce_n;
  assign flash_oe_n_out = bus.oe_n;
  assign flash_we_n_out = bus.we_n;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_we_pulse;
    !flash_we_n_out ##1 flash_we_n_out;
  endsequence
  sequence s_cmd_take;
    take && avs_write_in && avs_address_in == fcs_pkg::REG_CMD;
  endsequence

  a_unlock_first: assert property ( // [R1]
    (state == S_WLOW && step == 3'd0 && op == fcs_pkg::OP_BYP_ENTER) |->
    (flash_addr_out[10:0] & fcs_pkg::CMD_ADDR_MASK) == 11'h555 &&
    flash_dq_out == fcs_pkg::D_UNLOCK1)
    else $error("bypass entry does not open with the unlock write");
  a_bypass_set: assert property ( // [R1]
    (state == S_WHOLD && op == fcs_pkg::OP_BYP_ENTER && step == 3'd2) |=>
    bypass)
    else $error("bypass mode not recorded after entry");
  a_bypass_prog: assert property ( // [R3]
    (state == S_WLOW && op == fcs_pkg::OP_PROG && bypass && step == 3'd1)
    |-> flash_dq_out == cmd_data && flash_addr_out == cmd_addr)
    else $error("bypass program second write lacks target or value");
  a_bypass_exit: assert property ( // [R5]
    (state == S_WHOLD && op == fcs_pkg::OP_BYP_RESET && step == 3'd1) |=>
    !bypass && state == S_IDLE)
    else $error("bypass mode kept after exit");
  a_write_strobe: assert property ( // [R8]
    $fell(flash_we_n_out) |-> !flash_ce_n_out && !flash_dq_oe_n_out &&
    flash_oe_n_out ##0 s_we_pulse)
    else $error("write strobe malformed");
  a_chip_last: assert property ( // [R10]
    (state == S_WLOW && op == fcs_pkg::OP_CHIP && step == 3'd5) |->
    flash_dq_out == fcs_pkg::D_CHIP && flash_addr_out[10:0] == 11'h555)
    else $error("chip erase sixth write wrong");
  a_suspend_wait: assert property ( // [R18]
    (state == S_WHOLD && op == fcs_pkg::OP_SUSPEND) |=>
    (state == S_DELAY) [*8])
    else $error("suspend halt wait cut short");
  a_late_add: assert property ( // [R16]
    (s_cmd_take and state == S_IDLE && win_cnt == 10'h000 &&
    avs_writedata_in[3:0] == fcs_pkg::OP_BLOCK_ADD) |=>
    state == S_IDLE && (late || refused))
    else $error("block added after the selection window");
  a_error_hold: assert property ( // [R13]
    $fell(poll_err) |-> $past(state) == S_WHOLD &&
    (op == fcs_pkg::OP_RESET1 || op == fcs_pkg::OP_RESET3))
    else $error("error cleared without read/reset");
endmodule

// ==== verif/fcs_flash_model.sv ====
// behavioural flash device that answers the host's bus cycles
`timescale 1ns/100ps
module fcs_flash_model #(
  parameter int BUSY_RD = 3,
  parameter int WIN_NS = 50000
) (
  input wire logic [18:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [16];
  logic [7:0] last = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [3:0] blk = 4'h0;
  logic toggle_flag = 1'b0;
  logic win = 1'b0;
  logic susp = 1'b0;
  logic fail = 1'b0;
  int st, busy, mode, ret, ncmd;
  time t_sel;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // a released bus shows the inverse, so a stale byte never passes
  assign dq_out = (!ce_n_in && !oe_n_in) ? last : ~last;
  task automatic prog();
    // asking for a one on a cleared bit fails and holds the error
    fail = |(~mem[addr_in[3:0]] & dq_in);
    mem[addr_in[3:0]] &= dq_in;
    pd = dq_in;
    ret = (mode == 1) ? 0 : mode;
    mode = 3;
    busy = BUSY_RD;
    st = 0;
  endtask
  always @(posedge we_n_in) begin : wr
    logic [10:0] a;
    logic [7:0] d;
    a = addr_in[10:0];
    d = dq_in;
    ncmd++;
    if ((mode == 3 || mode == 4) && !fail) begin end
    else if (mode == 2) begin
      if (st == 1) prog();
      else begin
        if (st == 2 && d == 8'h00) mode = 0;
        st = (d == 8'ha0) ? 1 : (d == 8'h90) ? 2 : 0;
      end
    end else if (d == 8'hf0) begin
      mode = (mode == 3) ? ret : susp ? 6 : 0;
      fail = 1'b0;
      st = 0;
    end else if (mode == 5) begin
      if (d == 8'hb0) begin
        susp = 1'b1;
        mode = 6;
      end else if (d == 8'h30 && win && $time - t_sel < WIN_NS) begin
        blk[addr_in[3:2]] = 1'b1;
        t_sel = $time;
      end
    end else if (mode == 6 && st == 0 && d == 8'h30) begin
      mode = 5;
      win = 1'b0;
    end else case (st)
      0, 4: st = (a == 11'h555 && d == 8'haa) ? st + 1 : 0;
      1, 5: st = (a == 11'h2aa && d == 8'h55) ? st + 1 : 0;
      3: prog();
      2: begin
        st = (a != 11'h555) ? 0 : (d == 8'ha0) ? 3 : (d == 8'h80) ? 4 : 0;
        if (a == 11'h555 && d == 8'h90) mode = 1;
        if (a == 11'h555 && d == 8'h20) mode = 2;
      end
      6: begin
        st = 0;
        busy = BUSY_RD;
        blk = 4'h0;
        blk[addr_in[3:2]] = 1'b1;
        if (d == 8'h30) begin
          mode = 5;
          win = 1'b1;
          t_sel = $time;
        end else if (a == 11'h555 && d == 8'h10) begin
          mode = 4;
          blk = 4'hf;
        end
      end
      default: st = 0;
    endcase
  end
  always @(negedge oe_n_in) begin
    if (mode == 5 && win && $time - t_sel >= WIN_NS) win = 1'b0;
    if (mode == 1) last = 8'h00;
    else if (mode < 3 || (mode == 6 && !blk[addr_in[3:2]]))
      last = mem[addr_in[3:0]];
    else begin
      if (mode != 6) toggle_flag = ~toggle_flag;
      last = {mode == 6 || (mode == 3 && !pd[7]), toggle_flag, fail, 1'b0,
        mode != 5 || !win, 3'b000};
      if (mode != 6 && !win && !fail && --busy <= 0) begin
        if (mode == 3) mode = ret;
        else begin
          foreach (mem[i]) if (blk[i / 4]) mem[i] = 8'hff;
          mode = 0;
          susp = 1'b0;
        end
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the flash command sequencer host
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] avs_address_in = 3'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, q;
  logic avs_waitrequest_out, flash_dq_oe_n_out;
  logic [18:0] flash_addr_out;
  logic [7:0] flash_dq_out, dev_dq, dq_wire;
  logic flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
  int fails = 0;
  int comparisons = 0;
  assign dq_wire = flash_dq_oe_n_out ? dev_dq : flash_dq_out;
  always #50 clk_in = ~clk_in;
  fcs_host i_fcs_host (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .flash_addr_out, .flash_dq_out,
    .flash_dq_in(dq_wire), .flash_dq_oe_n_out, .flash_ce_n_out,
    .flash_oe_n_out, .flash_we_n_out);
  fcs_flash_model i_fcs_flash_model (.addr_in(flash_addr_out),
    .dq_in(dq_wire), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .dq_out(dev_dq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [2:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  // status is read until busy drops, so q ends as the settled status
  task automatic cmd(input logic [3:0] o);
    acc(3'h0, 1'b1, {28'h0, o});
    do acc(3'h3, 1'b0, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic cmdn(input logic [3:0] o, input int k);
    int c;
    c = i_fcs_flash_model.ncmd;
    cmd(o);
    chk(i_fcs_flash_model.ncmd - c, k);
  endtask
  task automatic test_done();
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(60000 * 100);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    acc(3'h3, 1'b0, 32'h0);
    chk(q, 32'h0);
    acc(3'h7, 1'b0, 32'h0);
    chk(q, 32'h0);
    chk({flash_ce_n_out, flash_oe_n_out, flash_we_n_out}, 3'h7);
    $display("test reset done");
    acc(3'h1, 1'b1, 32'h40003);
    acc(3'h2, 1'b1, 32'h5a);
    acc(3'h1, 1'b0, 32'h0);
    chk(q, 32'h40003);
    cmdn(4'h4, 4);
    cmd(4'hc);
    cmd(4'h0);
    acc(3'h4, 1'b0, 32'h0);
    chk(q, 32'h5a);
    acc(3'h2, 1'b1, 32'hff);
    cmd(4'h4);
    cmd(4'hc);
    chk(q[4], 1'b1);
    cmdn(4'h1, 1);
    chk(q[4], 1'b0);
    $display("test program done");
    cmdn(4'h5, 3);
    chk(q[1], 1'b1);
    acc(3'h0, 1'b1, 32'h7);
    acc(3'h3, 1'b0, 32'h0);
    chk(q[3], 1'b1);
    acc(3'h3, 1'b1, 32'h8);
    acc(3'h1, 1'b1, 32'h4);
    acc(3'h2, 1'b1, 32'h0f);
    cmdn(4'h4, 2);
    cmd(4'hc);
    chk(i_fcs_flash_model.mem[4], 8'h0f);
    cmdn(4'h6, 2);
    chk(q[3:0], 4'h0);
    $display("test bypass done");
    cmdn(4'h1, 1);
    cmdn(4'h2, 3);
    cmdn(4'h3, 3);
    chk(i_fcs_flash_model.mode, 1);
    cmd(4'h1);
    cmdn(4'h7, 6);
    cmd(4'hc);
    chk(i_fcs_flash_model.mem[3], 8'hff);
    chk(q[8:0], 9'h0);
    $display("test chip erase done");
    acc(3'h1, 1'b1, 32'hc);
    acc(3'h2, 1'b1, 32'h12);
    cmd(4'h4);
    cmd(4'hc);
    acc(3'h1, 1'b1, 32'h4);
    cmdn(4'h8, 6);
    acc(3'h1, 1'b1, 32'h8);
    cmdn(4'h9, 1);
    chk(i_fcs_flash_model.blk, 4'h6);
    acc(3'h0, 1'b1, 32'ha);
    cmd(4'h0);
    chk(q[3:2], 2'h3);
    cmdn(4'hb, 1);
    cmd(4'h9);
    chk(q[5], 1'b1);
    cmd(4'hc);
    chk(i_fcs_flash_model.mem[8], 8'hff);
    chk(i_fcs_flash_model.mem[12], 8'h12);
    $display("test block erase done");
    test_done();
  end
endmodule
